/* verilog/irq_mask_second.sv */
// Second interrupt mask register and its gating of four status events.
// Functional notes
// R1 - Bit 3 masks load-current-ready; resets to 1.
// R2 - Bit 2 masks undervoltage lock-out; resets to 0.
// R3 - Bit 1 masks thermal warning; resets to 1.
// R4 - Bit 0 masks temperature level changes; resets 1.
// R5 - Upper four bits read/write, reset zero, inert.
`timescale 1ns/1ps
`default_nettype none
`include "irq_mask2_defines.svh"
module irq_mask_second (
  // Clock, reset and enable.
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic CE,
  // Register access from the serial control interface.
  input wire irq_mask2_pkg::reg_access_t REG_ACC,
  output logic [7:0] REG_RDATA,
  // Status flags from the converter.
  input wire irq_mask2_pkg::status_flags_t FLAGS,
  // Unmasked requests and register view.
  output logic IRQ_REQ,
  output logic [7:0] MASK_VALUE
);
  import irq_mask2_pkg::*;

  logic [7:0] mask_r;
  logic temp_changed;
  logic irq_nxt;
  logic hit;
  logic [`MASK2_EVENTS-1:0] src_evt;
  wire logic [`MASK2_EVENTS-1:0] src_pass;

  // Only the one address of this register is decoded.
  assign hit = REG_ACC.addr == `MASK2_ADDR;

  temp_change_detect #(.WIDTH(2)) u_temp (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .ce(CE),
    .level(FLAGS.temp_level),
    .changed(temp_changed)
  );

  // Reset value puts bits 3, 1 and 0 high and bit 2 and the spares low.
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      mask_r <= `MASK2_RESET; // [R1] [R2] [R3] [R4] [R5]
    end else if (CE && REG_ACC.wr_en && hit) begin
      mask_r <= REG_ACC.wdata; // [R5]
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_RDATA <= `MASK2_READ_IDLE;
    end else if (CE && REG_ACC.rd_en) begin
      REG_RDATA <= hit ? mask_r : `MASK2_READ_IDLE;
    end
  end

  // Each source sits at the index of the mask bit that gates it, so one
  // loop covers all four; the spare bits lie above the loop and stay inert.
  always_comb begin
    src_evt = '0;
    src_evt[`MASK2_BIT_ILOAD] = FLAGS.current_meas_done; // [R1]
    src_evt[`MASK2_BIT_UNDERVOLT] = FLAGS.undervoltage_lockout_flag; // [R2]
    src_evt[`MASK2_BIT_TWARN] = FLAGS.thermal_warn; // [R3]
    src_evt[`MASK2_BIT_TEMP] = temp_changed; // [R4]
  end

  for (genvar i = 0; i < `MASK2_EVENTS; i++) begin : g_gate
    // A set mask bit blocks its source; a clear one lets it through.
    assign src_pass[i] = src_evt[i] && !mask_r[i]; // [R1] [R2] [R3] [R4]
  end

  assign irq_nxt = |src_pass; // [R5]

  // The request is a level that follows the sources on every enabled
  // edge; any latching of it is left to the logic outside this block.
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      IRQ_REQ <= 1'b0;
    end else if (CE) begin
      IRQ_REQ <= irq_nxt;
    end
  end

  // The register view trails the mask by one cycle.
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      MASK_VALUE <= `MASK2_RESET;
    end else if (CE) begin
      MASK_VALUE <= mask_r;
    end
  end

  // An unmasked source must raise the request on the next edge.
  a_meas_gate: assert property ( // [R1]
    @(posedge CORE_CLK) disable iff (!RSTN)
    CE && FLAGS.current_meas_done && !mask_r[`MASK2_BIT_ILOAD]
    |=> IRQ_REQ)
    else $error("load-current flag unmasked but no request");
  a_undervolt_gate: assert property ( // [R2]
    @(posedge CORE_CLK) disable iff (!RSTN)
    CE && FLAGS.undervoltage_lockout_flag && !mask_r[`MASK2_BIT_UNDERVOLT]
    |=> IRQ_REQ)
    else $error("undervoltage flag unmasked but no request");
  a_twarn_gate: assert property ( // [R3]
    @(posedge CORE_CLK) disable iff (!RSTN)
    CE && FLAGS.thermal_warn && !mask_r[`MASK2_BIT_TWARN]
    |=> IRQ_REQ)
    else $error("thermal flag unmasked but no request");
  a_temp_gate: assert property ( // [R4]
    @(posedge CORE_CLK) disable iff (!RSTN)
    CE && temp_changed && !mask_r[`MASK2_BIT_TEMP]
    |=> IRQ_REQ)
    else $error("temperature change unmasked but no request");

  // No request may appear unless some source is present and unmasked.
  a_no_spurious: assert property ( // [R1] [R2] [R3] [R4]
    @(posedge CORE_CLK) disable iff (!RSTN)
    CE && !(FLAGS.current_meas_done && !mask_r[`MASK2_BIT_ILOAD])
    && !(FLAGS.undervoltage_lockout_flag && !mask_r[`MASK2_BIT_UNDERVOLT])
    && !(FLAGS.thermal_warn && !mask_r[`MASK2_BIT_TWARN])
    && !(temp_changed && !mask_r[`MASK2_BIT_TEMP])
    |=> !IRQ_REQ)
    else $error("request raised with no unmasked source");
  a_all_masked: assert property ( // [R5]
    @(posedge CORE_CLK) disable iff (!RSTN)
    CE && mask_r[`MASK2_EVENTS-1:0] == `MASK2_ALL_MASKED
    |=> !IRQ_REQ)
    else $error("request raised with all mask bits set");

  // Register access.
  a_write_stores: assert property ( // [R5]
    @(posedge CORE_CLK) disable iff (!RSTN)
    CE && REG_ACC.wr_en && hit |=> mask_r == $past(REG_ACC.wdata))
    else $error("mask write not stored");
  a_write_other: assert property ( // [R5]
    @(posedge CORE_CLK) disable iff (!RSTN)
    CE && REG_ACC.wr_en && !hit |=> mask_r == $past(mask_r))
    else $error("write to another address changed the mask");
  a_read_back: assert property ( // [R5]
    @(posedge CORE_CLK) disable iff (!RSTN)
    CE && REG_ACC.rd_en && hit && !REG_ACC.wr_en
    |=> REG_RDATA == $past(mask_r))
    else $error("mask read returned wrong value");
  a_read_other: assert property ( // [R5]
    @(posedge CORE_CLK) disable iff (!RSTN)
    CE && REG_ACC.rd_en && !hit |=> REG_RDATA == `MASK2_READ_IDLE)
    else $error("read of another address returned data");
  a_read_holds: assert property ( // [R5]
    @(posedge CORE_CLK) disable iff (!RSTN)
    !(CE && REG_ACC.rd_en) |=> $stable(REG_RDATA))
    else $error("read data changed without a read");
  a_view_follows: assert property ( // [R5]
    @(posedge CORE_CLK) disable iff (!RSTN)
    CE |=> MASK_VALUE == $past(mask_r))
    else $error("mask view does not trail the mask");

  // A low clock enable freezes every piece of state.
  a_enable_freeze: assert property ( // [R5]
    @(posedge CORE_CLK) disable iff (!RSTN)
    !CE |=> $stable(mask_r) && $stable(IRQ_REQ) && $stable(MASK_VALUE))
    else $error("state moved while the clock enable was low");

  // Reset values, seen on the first edge after release.
  a_reset_value: assert property ( // [R1]
    @(posedge CORE_CLK)
    $rose(RSTN) |-> mask_r == `MASK2_RESET)
    else $error("mask reset value wrong");
  a_reset_undervolt: assert property ( // [R2]
    @(posedge CORE_CLK)
    $rose(RSTN) |-> !mask_r[`MASK2_BIT_UNDERVOLT])
    else $error("undervoltage mask bit not clear after reset");
  a_reset_twarn: assert property ( // [R3]
    @(posedge CORE_CLK)
    $rose(RSTN) |-> mask_r[`MASK2_BIT_TWARN])
    else $error("thermal mask bit not set after reset");
  a_reset_temp: assert property ( // [R4]
    @(posedge CORE_CLK)
    $rose(RSTN) |-> mask_r[`MASK2_BIT_TEMP])
    else $error("temperature mask bit not set after reset");
  a_reset_spare: assert property ( // [R5]
    @(posedge CORE_CLK)
    $rose(RSTN) |-> mask_r[`MASK2_SPARE_HI:`MASK2_SPARE_LO] == '0)
    else $error("spare mask bits not clear after reset");
  a_reset_outputs: assert property ( // [R5]
    @(posedge CORE_CLK)
    $rose(RSTN) |-> !IRQ_REQ && REG_RDATA == `MASK2_READ_IDLE
    && MASK_VALUE == `MASK2_RESET)
    else $error("outputs not at reset values after release");

  // The level history flags a change only when the level really moved.
  a_temp_quiet: assert property ( // [R4]
    @(posedge CORE_CLK) disable iff (!RSTN)
    CE ##1 (FLAGS.temp_level == $past(FLAGS.temp_level))
    |-> !temp_changed)
    else $error("temperature change flagged for a steady level");
  a_temp_seen: assert property ( // [R4]
    @(posedge CORE_CLK) disable iff (!RSTN)
    CE ##1 (FLAGS.temp_level != $past(FLAGS.temp_level))
    |-> temp_changed)
    else $error("temperature level moved but no change flagged");

  // Main scenarios.
  c_undervolt_irq: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
    FLAGS.undervoltage_lockout_flag ##1 IRQ_REQ);
  c_meas_irq: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
    FLAGS.current_meas_done && !mask_r[`MASK2_BIT_ILOAD] ##1 IRQ_REQ);
  c_temp_irq: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
    temp_changed && !mask_r[`MASK2_BIT_TEMP] ##1 IRQ_REQ);
  c_write: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
    CE && REG_ACC.wr_en && hit);
  c_enable_hold: cover property (@(posedge CORE_CLK) disable iff (!RSTN)
    !CE && REG_ACC.wr_en && hit);
endmodule
`default_nettype wire

/* include/irq_mask2_defines.svh */
// Register address, field positions and reset values of the second mask.
`ifndef IRQ_MASK2_DEFINES_SVH
`define IRQ_MASK2_DEFINES_SVH
`define MASK2_ADDR 8'h2e
`define MASK2_RESET 8'h0b
`define MASK2_BIT_ILOAD 3
`define MASK2_BIT_UNDERVOLT 2
`define MASK2_BIT_TWARN 1
`define MASK2_BIT_TEMP 0
`define MASK2_SPARE_LO 4
`define MASK2_SPARE_HI 7
`define MASK2_EVENTS 4
`define MASK2_ALL_MASKED 4'hf
`define MASK2_READ_IDLE 8'h00
`endif

/* include/irq_mask2_pkg.sv */
// Types shared by the second interrupt mask block.
package irq_mask2_pkg;
  typedef struct packed {
    logic current_meas_done;
    logic undervoltage_lockout_flag;
    logic thermal_warn;
    logic [1:0] temp_level;
  } status_flags_t;
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_t;
endpackage

/* verilog/temp_change_detect.sv */
// Detects a change of the two-bit die temperature level field.
`timescale 1ns/1ps
`default_nettype none
`include "irq_mask2_defines.svh"
module temp_change_detect #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] level,
  output logic changed
);
  logic [WIDTH-1:0] prev_r;
  logic primed_r;

  // The first sample after reset only primes the history.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= '0;
      primed_r <= 1'b0;
    end else if (ce) begin
      prev_r <= level;
      primed_r <= 1'b1;
    end
  end

  assign changed = primed_r && (prev_r != level);
endmodule
`default_nettype wire

/* dv/host_model.sv */
// Host model issuing register accesses.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk,
  output var irq_mask2_pkg::reg_access_t acc
);
  import irq_mask2_pkg::*;
  initial acc = '0;
  // Holds one request across one rising edge, then releases it.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) acc = '{w, !w, a, d};
    @(negedge clk) acc = '0;
  endtask
endmodule
`default_nettype wire

/* dv/tb_irq_mask_second.sv */
// Self-checking bench for the second interrupt mask.
`timescale 1ns/1ps
`default_nettype none
module tb_irq_mask_second;
  import irq_mask2_pkg::*;
  logic clk = 0;
  logic rstn = 0;
  logic ce = 1;
  status_flags_t flags = '0;
  reg_access_t acc;
  logic [7:0] rdata;
  logic [7:0] mval;
  logic irq;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  host_model u_host_model (.clk(clk), .acc(acc));
  irq_mask_second u_irq_mask_second (.CORE_CLK(clk), .RSTN(rstn), .CE(ce),
    .REG_ACC(acc), .REG_RDATA(rdata), .FLAGS(flags), .IRQ_REQ(irq),
    .MASK_VALUE(mval));
  task automatic conclude();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors++;
      conclude();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_host_model.xfer(1'b0, a, 8'h00);
    chk("rdata", e, rdata);
  endtask
  task automatic wr(input logic [7:0] d);
    u_host_model.xfer(1'b1, 8'h2e, d);
    @(negedge clk);
  endtask
  task automatic reset_values();
    chk("mask", 8'h0b, mval);
    rd(8'h2e, 8'h0b);
    rd(8'h2f, 8'h00);
  endtask
  task automatic gating();
    logic [7:0] en;
    for (int b = 1; b < 4; b++) begin
      en = 8'h01 << b;
      flags = status_flags_t'(5'h01 << (b + 1));
      wr(8'h0f ^ en);
      chk("irq on", 8'h01, {7'h0, irq});
      wr(8'hf0 | en);
      chk("irq off", 8'h00, {7'h0, irq});
    end
  endtask
  task automatic temp_change();
    flags = '0;
    wr(8'h00);
    flags.temp_level = 2'h2;
    @(negedge clk);
    chk("temp on", 8'h01, {7'h0, irq});
    @(negedge clk);
    chk("temp end", 8'h00, {7'h0, irq});
    wr(8'h01);
    flags.temp_level = 2'h1;
    @(negedge clk);
    chk("temp off", 8'h00, {7'h0, irq});
  endtask
  task automatic spare_bits();
    wr(8'ha5);
    chk("mask", 8'ha5, mval);
    rd(8'h2e, 8'ha5);
    u_host_model.xfer(1'b1, 8'h2f, 8'h00);
    @(negedge clk);
    chk("mask", 8'ha5, mval);
  endtask
  task automatic ce_hold();
    ce = 1'b0;
    wr(8'h00);
    ce = 1'b1;
    chk("mask", 8'ha5, mval);
    rd(8'h2e, 8'ha5);
  endtask
  task automatic reset_again();
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    chk("irq rst", 8'h00, {7'h0, irq});
    rstn = 1'b1;
    @(negedge clk);
    chk("mask", 8'h0b, mval);
    rd(8'h2e, 8'h0b);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1;
    @(negedge clk);
    reset_values();
    gating();
    temp_change();
    spare_bits();
    ce_hold();
    reset_again();
    conclude();
  end
endmodule
`default_nettype wire
